// ==== rtl/mmd_pkg.sv ====
// package: memory map constants, region codes and access carrier types
package mmd_pkg;

   // ==========================================================================
   // address map
   localparam logic [31:0] LOW_WIN_BASE   = 32'h0000_0000;
   localparam logic [31:0] LOW_WIN_BYTES  = 32'h0001_7800;  // 94 kB remappable window
   localparam logic [31:0] SRAM_BASE      = 32'h0004_0000;
   localparam int          SRAM_WORDS     = 1536;
   localparam logic [31:0] SRAM_BYTES     = 32'h0000_1800;  // 1536 words of 4 bytes
   localparam logic [31:0] NVM_BASE       = 32'h0008_0000;
   localparam logic [31:0] NVM_BYTES      = 32'h0001_8000;  // 96 kB total
   localparam logic [31:0] BOOT_BYTES     = 32'h0000_0800;  // 2 kB hidden boot area
   localparam logic [31:0] USER_NVM_BYTES = 32'h0001_7800;  // 94 kB for user
   localparam logic [31:0] MPR_BASE       = 32'hFFFF_F000;  // top 4 kB
   localparam logic [31:0] MAP_CTRL_ADDR  = 32'hFFFF_0220;
   localparam int          MAP_CTRL_W     = 8;
   localparam logic [7:0]  MAP_CTRL_RST   = 8'h00;
   localparam int          REMAP_BIT      = 0;

   // ==========================================================================
   // exception vectors and boot check
   localparam logic [31:0] VEC_TOP        = 32'h0000_0020;
   localparam logic [4:0]  VEC_RESET      = 5'h00;
   localparam logic [4:0]  VEC_UNDEF      = 5'h04;
   localparam logic [4:0]  VEC_TRAP       = 5'h08;
   localparam logic [4:0]  VEC_PABT       = 5'h0C;
   localparam logic [4:0]  VEC_DABT       = 5'h10;
   localparam logic [4:0]  VEC_CHECK      = 5'h14;
   localparam logic [4:0]  VEC_IRQ        = 5'h18;
   localparam logic [4:0]  VEC_FIQ        = 5'h1C;
   localparam logic [31:0] BOOT_MAGIC     = 32'h2701_1970;

   // ==========================================================================
   // types
   typedef enum logic [2:0] {
      RG_NONE = 3'b000,
      RG_SRAM = 3'b001,
      RG_NVM  = 3'b010,
      RG_MPR  = 3'b011,
      RG_CTRL = 3'b100
   } mmd_region_t;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_HALF = 2'b01,
      SZ_WORD = 2'b10
   } mmd_size_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        fetch;
      logic        kernel;
      mmd_size_t   size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mmd_req_t;

   typedef struct packed {
      logic        reset;
      logic        dataAbort;
      logic        fiq;
      logic        irq;
      logic        prefetchAbort;
      logic        softwareTrap;
      logic        undefInstr;
   } mmd_exc_t;

endpackage

// ==== rtl/mmd_memory_map_remap_decoder.sv ====
// memory map decoder with remappable low window and map control register
`timescale 1ns/1ps

// Summary of operation
// - lowest 94 kB mirror NVM, or SRAM in their lowest 6 kB only
// - top 4 kB decodes peripheral register area
// - SRAM is 1536 words at 0x00040000
// - NVM 96 kB, 2 kB boot code reserved
// - unmapped access raises data abort
// - multi-byte data stored little endian
// - SRAM supports 8, 16, 32-bit accesses
// - vectors 0x00-0x20 served by mirrored memory
// - exceptions prioritised reset, dabt, fiq, irq...
// - map control bit 0 selects SRAM at zero
// - rst_b reset restores NVM at zero; excReq.reset only selects the reset vector
// - after reset boot code runs first
// - boot code region hidden from user code
// - location 0x14 validates user code start
// - NVM also decoded at 0x80000
module mmd_memory_map_remap_decoder
   import mmd_pkg::*;
#(
   parameter int SRAM_DEPTH = SRAM_WORDS
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // core access, one cycle request
   input  wire mmd_req_t    req,
   output logic [31:0]      rdata,
   output logic             rvalid,
   output logic             dataAbort,
   // nonvolatile memory read port (external array)
   output logic             nvmSel,
   output logic [16:0]      nvmAddr,
   input  wire logic [31:0] nvmRdata,
   // peripheral register area strobe
   output logic             mprSel,
   // boot check: word stored at 0x14 and page 0 checksum
   input  wire logic [31:0] vecCheckWord,
   input  wire logic [31:0] page0Checksum,
   input  wire logic        bootDone,
   output logic             userCodeOk,
   output logic             serialDownload,
   // exception requests and chosen vector
   input  wire mmd_exc_t    excReq,
   output logic [4:0]       excVector,
   output logic             excTaken,
   // map state
   output logic             sramAtZero
);

   localparam int AW = $clog2(SRAM_DEPTH);

   // ==========================================================================
   // state
   wire logic [31:0]     sramWord;   // word assembled from the four lane arrays
   logic [MAP_CTRL_W-1:0] mapCtrl_ff, nxt_mapCtrl;
   logic [31:0]          rdata_ff, nxt_rdata;
   logic                 rvalid_ff, nxt_rvalid;
   logic                 abort_ff, nxt_abort;
   logic [4:0]           vec_ff, nxt_vec;
   logic                 taken_ff, nxt_taken;

   // decode region for an address under the current map
   function automatic mmd_region_t decodeRegion(input logic [31:0] a, input logic remap,
                                                input logic kern);
      mmd_region_t r;
      r = RG_NONE;
      if (a < LOW_WIN_BYTES) begin
         if (remap) r = (a < SRAM_BYTES) ? RG_SRAM : RG_NONE;
         else       r = RG_NVM;
      end else if (a >= SRAM_BASE && a < SRAM_BASE + SRAM_BYTES) begin
         r = RG_SRAM;
      end else if (a >= NVM_BASE && a < NVM_BASE + NVM_BYTES) begin
         // boot area at top of NVM is only visible to the boot code
         if (kern || (a - NVM_BASE) < USER_NVM_BYTES) r = RG_NVM;
      end else if (a == MAP_CTRL_ADDR) begin
         r = RG_CTRL;
      end else if (a >= MPR_BASE) begin
         r = RG_MPR;
      end
      return r;
   endfunction

   // byte lane enables for little endian lanes
   function automatic logic [3:0] laneMask(input mmd_size_t sz, input logic [1:0] lo);
      logic [3:0] m;
      unique case (sz)
         SZ_BYTE: m = 4'h1 << lo;
         SZ_HALF: m = lo[1] ? 4'hC : 4'h3;
         default: m = 4'hF;
      endcase
      return m;
   endfunction

   mmd_region_t region;
   logic [31:0] offs;
   logic [AW-1:0] sramIdx;
   logic [3:0]  lanes;

   // address path, combinational toward the array ports
   always_comb begin
      region  = decodeRegion(req.addr, mapCtrl_ff[REMAP_BIT], req.kernel);
      offs    = (req.addr < LOW_WIN_BYTES) ? req.addr :
                ((region == RG_SRAM) ? req.addr - SRAM_BASE : req.addr - NVM_BASE);
      sramIdx = offs[AW+1:2];
      lanes   = laneMask(req.size, req.addr[1:0]);
      nvmSel  = req.valid && !req.write && region == RG_NVM;
      nvmAddr = offs[16:0];
      mprSel  = req.valid && region == RG_MPR;
   end

   // ==========================================================================
   // SRAM array with byte lanes; lane 0 is the lowest byte address
   // one array per lane, so every array has exactly one writing process
   generate
      for (genvar b = 0; b < 4; b++) begin : g_lane
         logic [7:0] laneMem_ff [SRAM_DEPTH];
         always_ff @(posedge clock) begin
            if (req.valid && req.write && region == RG_SRAM && lanes[b])
               laneMem_ff[sramIdx] <= req.wdata[8*b +: 8];
         end
         assign sramWord[8*b +: 8] = laneMem_ff[sramIdx];
      end
   endgenerate

   // ==========================================================================
   // read data, abort and map control next values
   always_comb begin
      nxt_mapCtrl = mapCtrl_ff;
      nxt_rdata   = rdata_ff;
      nxt_rvalid  = 1'b0;
      nxt_abort   = 1'b0;
      if (req.valid) begin
         unique case (region)
            RG_NONE: nxt_abort = 1'b1;
            // read data only moves on a read, so it holds until the next one
            RG_SRAM: begin
               nxt_rvalid = !req.write;
               if (!req.write) nxt_rdata = sramWord;
            end
            RG_NVM: begin
               nxt_abort  = req.write;  // array writes go via its own controller
               nxt_rvalid = !req.write;
               if (!req.write) nxt_rdata = nvmRdata;
            end
            RG_CTRL: begin
               // reserved bits are stored as written; software keeps them zero
               if (req.write) nxt_mapCtrl = req.wdata[MAP_CTRL_W-1:0];
               else           nxt_rdata   = {24'h00_0000, mapCtrl_ff};
               nxt_rvalid = !req.write;
            end
            RG_MPR: nxt_rvalid = 1'b0; // peripherals answer on their own path
            default: nxt_abort = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mapCtrl_ff <= MAP_CTRL_RST;
         rdata_ff   <= 32'h0000_0000;
         rvalid_ff  <= 1'b0;
         abort_ff   <= 1'b0;
      end else begin
         mapCtrl_ff <= nxt_mapCtrl;
         rdata_ff   <= nxt_rdata;
         rvalid_ff  <= nxt_rvalid;
         abort_ff   <= nxt_abort;
      end
   end

   // ==========================================================================
   // exception arbitration, fixed priority
   always_comb begin
      nxt_taken = 1'b1;
      if      (excReq.reset)                                nxt_vec = VEC_RESET;
      else if (excReq.dataAbort || abort_ff)                nxt_vec = VEC_DABT;
      else if (excReq.fiq)                                  nxt_vec = VEC_FIQ;
      else if (excReq.irq)                                  nxt_vec = VEC_IRQ;
      else if (excReq.prefetchAbort)                        nxt_vec = VEC_PABT;
      else if (excReq.softwareTrap)                         nxt_vec = VEC_TRAP;
      else if (excReq.undefInstr)                           nxt_vec = VEC_UNDEF;
      else begin
         nxt_vec   = vec_ff;
         nxt_taken = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         vec_ff   <= VEC_RESET;
         taken_ff <= 1'b0;
      end else begin
         vec_ff   <= nxt_vec;
         taken_ff <= nxt_taken;
      end
   end

   // ==========================================================================
   // boot check: user code starts only with a valid word at 0x14;
   // the boot code itself must run first, so the verdict waits for bootDone
   logic ok;
   assign ok = (vecCheckWord == BOOT_MAGIC) || (vecCheckWord == page0Checksum);

   always_comb begin
      userCodeOk     = bootDone && ok;
      serialDownload = bootDone && !ok;
   end

   assign rdata      = rdata_ff;
   assign rvalid     = rvalid_ff;
   assign dataAbort  = abort_ff;
   assign excVector  = vec_ff;
   assign excTaken   = taken_ff;
   assign sramAtZero = mapCtrl_ff[REMAP_BIT];

endmodule

// ==== bench/mmd_nvm_model.sv ====
// model: nonvolatile array behind the decoder's combinational read port
`timescale 1ns/1ps
module mmd_nvm_model (
   // clock
   input  wire logic        clock,
   // array read port
   input  wire logic        nvmSel,
   input  wire logic [16:0] nvmAddr,
   output logic [31:0]      nvmRdata
);
   // ==========================================================================
   // same-cycle answer; idle bus flips every cycle so stale data never matches
   // starts at a known value so the idle inverse is never unknown
   logic [31:0] lastData_ff = 32'h0000_0000;
   always @(posedge clock) lastData_ff <= nvmRdata;
   assign nvmRdata = nvmSel ? (32'hA500_0000 | {15'h0, nvmAddr}) : ~lastData_ff;
endmodule

// ==== bench/mmd_memory_map_remap_decoder_monitor.sv ====
// checker: port relations of the memory map decoder
`timescale 1ns/1ps
module mmd_memory_map_remap_decoder_monitor
   import mmd_pkg::*;
#(
   parameter int SRAM_DEPTH = SRAM_WORDS
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // core access and answers
   input  wire mmd_req_t    req,
   input  wire logic        rvalid,
   input  wire logic        dataAbort,
   input  wire logic        nvmSel,
   input  wire logic [16:0] nvmAddr,
   input  wire logic        mprSel,
   // boot check, exceptions, map state
   input  wire logic [31:0] vecCheckWord,
   input  wire logic [31:0] page0Checksum,
   input  wire logic        bootDone,
   input  wire logic        userCodeOk,
   input  wire logic        serialDownload,
   input  wire mmd_exc_t    excReq,
   input  wire logic [4:0]  excVector,
   input  wire logic        sramAtZero
);
   // ==========================================================================
   // shorthands for address and read qualifier
   logic [31:0] a;
   logic        rd;
   assign a  = req.addr;
   assign rd = req.valid && !req.write;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   AST_HOLE: assert property (req.valid && a >= LOW_WIN_BYTES && a < SRAM_BASE |=> dataAbort)
      else $error("hole access not aborted");
   AST_BEYOND: assert property (req.valid && sramAtZero && a >= SRAM_DEPTH * 4 &&
      a < LOW_WIN_BYTES |=> dataAbort) else $error("window beyond sram not aborted");
   AST_SRAMRD: assert property (rd && a >= SRAM_BASE && a < SRAM_BASE + SRAM_BYTES
      |=> rvalid && !dataAbort) else $error("sram read not answered");
   AST_MPR: assert property (req.valid && a >= MPR_BASE |-> mprSel)
      else $error("peripheral area not selected");
   AST_REMAP: assert property (req.valid && req.write && a == MAP_CTRL_ADDR
      |=> sramAtZero == $past(req.wdata[0])) else $error("remap bit not taken");
   AST_RSTMAP: assert property ($rose(rst_b) |-> !sramAtZero)
      else $error("remap survived reset");
   AST_LOWNVM: assert property (rd && !sramAtZero && a < LOW_WIN_BYTES
      |-> nvmSel && nvmAddr == a[16:0]) else $error("low window not on nvm");
   AST_BOOTHIDE: assert property (req.valid && !req.kernel && a >= NVM_BASE + USER_NVM_BYTES
      && a < NVM_BASE + NVM_BYTES |=> dataAbort) else $error("boot area not hidden");
   AST_EXCRST: assert property (excReq.reset |=> excVector == VEC_RESET)
      else $error("reset vector not first");
   AST_ABTVEC: assert property (dataAbort && !excReq.reset |=> excVector == VEC_DABT)
      else $error("data abort vector not taken");
   AST_BOOTCHK: assert property (bootDone |-> userCodeOk == (vecCheckWord == BOOT_MAGIC ||
      vecCheckWord == page0Checksum) && serialDownload == !userCodeOk) else $error("boot check");
endmodule

bind mmd_memory_map_remap_decoder mmd_memory_map_remap_decoder_monitor #(
   .SRAM_DEPTH(SRAM_DEPTH)
) mon (
   .clock(clock), .rst_b(rst_b), .req(req), .rvalid(rvalid), .dataAbort(dataAbort),
   .nvmSel(nvmSel), .nvmAddr(nvmAddr), .mprSel(mprSel), .vecCheckWord(vecCheckWord),
   .page0Checksum(page0Checksum), .bootDone(bootDone), .userCodeOk(userCodeOk),
   .serialDownload(serialDownload), .excReq(excReq), .excVector(excVector),
   .sramAtZero(sramAtZero)
);

// ==== bench/mmd_memory_map_remap_decoder_bench.sv ====
// bench: directed scenarios for the memory map decoder
`timescale 1ns/1ps
module mmd_memory_map_remap_decoder_bench
   import mmd_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        bootDone = 1'b0;
   logic        kern = 1'b0;
   logic        rvalid, dataAbort, nvmSel, mprSel, userCodeOk, serialDownload, excTaken;
   logic        sramAtZero;
   logic [16:0] nvmAddr;
   logic [31:0] rdata, nvmRdata;
   logic [31:0] vecCheckWord = 32'h0;
   logic [31:0] page0Checksum = 32'h0;
   logic [4:0]  excVector;
   mmd_req_t    req = '0;
   mmd_exc_t    excReq = '0;
   int          errTotal = 0;
   int          checksDone = 0;
   always #4 clock = ~clock;
   mmd_memory_map_remap_decoder uut (.clock(clock), .rst_b(rst_b), .req(req), .rdata(rdata),
      .rvalid(rvalid), .dataAbort(dataAbort), .nvmSel(nvmSel), .nvmAddr(nvmAddr),
      .nvmRdata(nvmRdata), .mprSel(mprSel), .vecCheckWord(vecCheckWord),
      .page0Checksum(page0Checksum), .bootDone(bootDone), .userCodeOk(userCodeOk),
      .serialDownload(serialDownload), .excReq(excReq), .excVector(excVector),
      .excTaken(excTaken), .sramAtZero(sramAtZero));
   mmd_nvm_model nvm (.clock(clock), .nvmSel(nvmSel), .nvmAddr(nvmAddr), .nvmRdata(nvmRdata));
   // ==========================================================================
   // helpers
   function automatic logic [31:0] nvmW(input logic [31:0] off);
      return 32'hA500_0000 | {15'h0, off[16:0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errTotal++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held one cycle, answer looked at just after the edge that registers it
   task automatic acc(input logic wr, input mmd_size_t sz, input logic [31:0] ad,
                      input logic [31:0] wd);
      @(posedge clock);
      req <= '{valid:1'b1, write:wr, fetch:1'b0, kernel:kern, size:sz, addr:ad, wdata:wd};
      @(posedge clock);
      req.valid <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [31:0] ad, input logic [31:0] exp);
      acc(1'b0, SZ_WORD, ad, 32'h0);
      chk({30'h0, rvalid, dataAbort}, 32'h2);
      chk(rdata, exp);
   endtask
   task automatic ab(input logic wr, input logic [31:0] ad);
      acc(wr, SZ_WORD, ad, 32'h0);
      chk({31'h0, dataAbort}, 32'h1);
   endtask
   task automatic doReset();
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      #1;
      chk({26'h0, sramAtZero, excVector}, 32'h0);
   endtask
   // ==========================================================================
   // scenarios; byte and half data replicated so either lane reading works
   task automatic tSram();
      acc(1'b1, SZ_WORD, SRAM_BASE, 32'h4433_2211);
      acc(1'b1, SZ_BYTE, SRAM_BASE + 32'h1, 32'hAAAA_AAAA);
      acc(1'b1, SZ_HALF, SRAM_BASE + 32'h2, 32'hBEEF_BEEF);
      rd(SRAM_BASE, 32'hBEEF_AA11);
      acc(1'b1, SZ_WORD, SRAM_BASE + SRAM_BYTES - 32'h4, 32'h1234_5678);
      rd(SRAM_BASE + SRAM_BYTES - 32'h4, 32'h1234_5678);
      ab(1'b0, SRAM_BASE + SRAM_BYTES);
      ab(1'b0, LOW_WIN_BYTES);
      ab(1'b1, 32'hFFFE_0000);
   endtask
   task automatic tNvm();
      rd(32'h0000_0010, nvmW(32'h10));
      rd(NVM_BASE + 32'h100, nvmW(32'h100));
      ab(1'b1, NVM_BASE);
      ab(1'b0, NVM_BASE + USER_NVM_BYTES);
      kern = 1'b1;
      rd(NVM_BASE + USER_NVM_BYTES, nvmW(USER_NVM_BYTES));
      kern = 1'b0;
      acc(1'b0, SZ_WORD, MPR_BASE + 32'h4, 32'h0);
      chk({31'h0, dataAbort}, 32'h0);
   endtask
   task automatic tRemap();
      acc(1'b1, SZ_WORD, MAP_CTRL_ADDR, 32'h0000_0001);
      chk({31'h0, sramAtZero}, 32'h1);
      rd(32'h0, 32'hBEEF_AA11);
      ab(1'b0, SRAM_BYTES);
      rd(MAP_CTRL_ADDR, 32'h1);
      acc(1'b1, SZ_WORD, MAP_CTRL_ADDR, 32'h0);
      chk(rdata, 32'h1);
      chk({31'h0, sramAtZero}, 32'h0);
      rd(32'h4, nvmW(32'h4));
      acc(1'b1, SZ_WORD, MAP_CTRL_ADDR, 32'h0000_0001);
      doReset();
      rd(32'h0, nvmW(32'h0));
   endtask
   // each request alone, then mixes where the higher one must win
   task automatic tExc();
      logic [6:0] reqs [12] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01,
                                 7'h7F, 7'h30, 7'h18, 7'h0C, 7'h06};
      logic [4:0] vecs [12] = '{5'h00, 5'h10, 5'h1C, 5'h18, 5'h0C, 5'h08, 5'h04,
                                 5'h00, 5'h10, 5'h1C, 5'h18, 5'h0C};
      for (int i = 0; i < 12; i++) begin
         @(posedge clock);
         excReq <= reqs[i];
         @(posedge clock);
         excReq <= '0;
         #1;
         chk({26'h0, excTaken, excVector}, {26'h0, 1'b1, vecs[i]});
      end
   endtask
   task automatic tBoot();
      logic [31:0] words [3] = '{BOOT_MAGIC, 32'h0BAD_0001, 32'h1357_9BDF};
      chk({30'h0, userCodeOk, serialDownload}, 32'h0);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         bootDone <= 1'b1;
         page0Checksum <= 32'h0BAD_0001;
         vecCheckWord <= words[i];
         @(posedge clock);
         #1;
         chk({30'h0, userCodeOk, serialDownload}, (i < 2) ? 32'h2 : 32'h1);
      end
   endtask
   task automatic wrapUp();
      if (errTotal == 0 && checksDone > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================================================================
   // main sequence and watchdog
   initial begin
      doReset();
      tSram();
      tNvm();
      tRemap();
      tExc();
      tBoot();
      wrapUp();
   end
   initial begin
      repeat (3000) @(posedge clock);
      errTotal++;
      wrapUp();
   end
endmodule
